// File: src/dec_alu_pkg.sv
// Constants shared by the signed decimal add and multiply datapath.
package dec_alu_pkg;
	localparam int          NUM_AR       = 4;
	localparam int          DIGITS       = 6;
	localparam int          EXT_DIGITS   = 7;
	localparam int          MAG_W        = 24;
	localparam int          EXT_W        = 28;
	localparam int          WORD_W       = 25;
	localparam int          SIGN_POS     = 24;
	localparam logic [1:0]  OP_ADD       = 2'h0;
	localparam logic [1:0]  OP_SUB       = 2'h1;
	localparam logic [1:0]  OP_MUL       = 2'h2;
	localparam logic [3:0]  XS3_BIAS     = 4'h3;
	localparam logic [3:0]  XS3_ZERO     = 4'h3;
	localparam logic [3:0]  BIN_ZERO     = 4'h0;
	localparam logic [3:0]  COMP_LIMIT   = 4'h5;
	localparam logic [3:0]  RADIX        = 4'ha;
	localparam logic [23:0] XS3_ZERO_MAG = 24'h333333;
	localparam logic [24:0] AR_RESET     = 25'h0000000;
	localparam logic [2:0]  LAST_DIGIT   = 3'h5;
	localparam int          MUL_SRC      = 0;
	localparam int          PROD_LO      = 1;
	localparam int          PROD_HI      = 3;
endpackage : dec_alu_pkg

// File: src/signed_decimal_add_multiply.sv
// Signed-magnitude binary and excess-three decimal add and subtract, and excess-three decimal multiply datapath.
`timescale 1ns/1ps
module signed_decimal_add_multiply (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_rst_b,
	// Arithmetic register load port.
	input  wire logic          i_load_en,
	input  wire logic [1:0]    i_load_sel,
	input  wire logic [24:0]   i_load_word,
	// Instruction request.
	input  wire logic          i_start,
	input  wire logic [1:0]    i_op,
	input  wire logic          i_decimal,
	input  wire logic [3:0]    i_ar_mask,
	input  wire logic [24:0]   i_mem_word,
	// Status and register contents.
	output logic               o_busy,
	output logic               o_done,
	output logic               o_eq_flag,
	output logic [99:0]        o_ar_words
);
	// *****************************************************************
	// Arithmetic helpers
	// *****************************************************************
	// Seven-digit add in 4-bit groups; the top digit shows the carry.
	function automatic logic [27:0] add_ext(input logic [27:0] a, input logic [27:0] b,
	                                         input logic dec);
		logic [27:0] r;
		logic        c;
		logic [4:0]  s;
		r = 28'h0;
		c = 1'b0;
		for (int i = 0; i < dec_alu_pkg::EXT_DIGITS; i++) begin
			s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
			c = s[4];
			if (dec) begin
				r[i*4 +: 4] = c ? s[3:0] + dec_alu_pkg::XS3_BIAS
				                : s[3:0] - dec_alu_pkg::XS3_BIAS;
			end else begin
				r[i*4 +: 4] = s[3:0];
			end
		end
		return r;
	endfunction : add_ext

	// Ten's complement: trailing zeros kept, first nonzero from ten, rest from nine.
	function automatic logic [27:0] tc_ext(input logic [27:0] a, input logic dec);
		logic [27:0] r;
		logic        seen;
		r = 28'h0;
		seen = 1'b0;
		if (!dec) begin
			r = (~a) + 28'h1;
		end else begin
			for (int i = 0; i < dec_alu_pkg::EXT_DIGITS; i++) begin
				if (seen) begin
					r[i*4 +: 4] = ~a[i*4 +: 4];
				end else if (a[i*4 +: 4] == dec_alu_pkg::XS3_ZERO) begin
					r[i*4 +: 4] = a[i*4 +: 4];
				end else begin
					r[i*4 +: 4] = (~a[i*4 +: 4]) + 4'h1;
					seen = 1'b1;
				end
			end
		end
		return r;
	endfunction : tc_ext

	// Widens a magnitude by one zero digit.
	function automatic logic [27:0] ext(input logic [23:0] m, input logic dec);
		return {dec ? dec_alu_pkg::XS3_ZERO : dec_alu_pkg::BIN_ZERO, m};
	endfunction : ext

	// *****************************************************************
	// State
	// *****************************************************************
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADD, ST_RC_SETUP, ST_RC, ST_FINISH,
		ST_MUL_PICK, ST_MUL_ADD, ST_MUL_SHIFT, ST_MUL_FIX, ST_MUL_STORE
	} state_t;

	state_t      state_reg;
	logic [24:0] ar_reg [0:3];
	logic [24:0] cpr_reg;
	logic [3:0]  mask_reg;
	logic        dec_reg;
	logic        sub_reg;
	logic [3:0]  rc_reg;
	logic [27:0] acc_reg;
	logic [23:0] lo_reg;
	logic [23:0] mq_reg;
	logic [3:0]  cnt_reg;
	logic [2:0]  idx_reg;
	logic        borrow_reg;
	logic        usecomp_reg;

	// Per-register add results, computed in parallel.
	logic [27:0] sum_w  [0:3];
	logic [3:0]  need_rc;
	logic [3:0]  zero_w;
	logic [27:0] rc_val;
	logic [1:0]  rc_idx;
	logic        mem_sign;
	logic        all_zero_w;
	logic        rc_sign_w;

	assign mem_sign = cpr_reg[dec_alu_pkg::SIGN_POS] ^ sub_reg;

	// Every selected register reads zero; sign of the word now being recomplemented.
	assign all_zero_w = &(zero_w | ~mask_reg);
	assign rc_sign_w  = ar_reg[rc_idx][dec_alu_pkg::SIGN_POS];

	// Add each register with the operand register; unequal signs complement it.
	always_comb begin
		logic [27:0] m_e;
		logic        uneq;
		uneq = 1'b0;
		m_e = ext(cpr_reg[23:0], dec_reg);
		need_rc = 4'h0;
		zero_w = 4'h0;
		for (int k = 0; k < dec_alu_pkg::NUM_AR; k++) begin
			uneq = ar_reg[k][dec_alu_pkg::SIGN_POS] != mem_sign;
			sum_w[k] = add_ext(ext(ar_reg[k][23:0], dec_reg),
			                   uneq ? tc_ext(m_e, dec_reg) : m_e, dec_reg);
			need_rc[k] = uneq && mask_reg[k] && (sum_w[k][27:24] !=
			             (dec_reg ? dec_alu_pkg::XS3_ZERO : dec_alu_pkg::BIN_ZERO));
			zero_w[k] = ar_reg[k][23:0] == (dec_reg ? dec_alu_pkg::XS3_ZERO_MAG : 24'h0);
		end
	end

	// Lowest register still waiting to be recomplemented.
	always_comb begin
		rc_idx = 2'h0;
		for (int k = dec_alu_pkg::NUM_AR - 1; k >= 0; k--) begin
			if (rc_reg[k]) begin
				rc_idx = 2'(k);
			end
		end
		rc_val = tc_ext(ext(ar_reg[rc_idx][23:0], dec_reg), dec_reg);
	end

	// Multiplier digit selection inputs.
	logic [3:0]  eff_digit;
	logic [27:0] mcand_ext;
	assign eff_digit = (mq_reg[3:0] - dec_alu_pkg::XS3_BIAS) + {3'h0, borrow_reg};
	assign mcand_ext = ext(cpr_reg[23:0], 1'b1);

	// *****************************************************************
	// Sequencer
	// *****************************************************************
	// Walks add, recomplement and multiply steps.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE:      if (i_start) state_reg <= (i_op == dec_alu_pkg::OP_MUL)
				                                         ? ST_MUL_PICK : ST_ADD;
				ST_ADD:       state_reg <= (|need_rc) ? ST_RC_SETUP : ST_FINISH;
				ST_RC_SETUP:  state_reg <= ST_RC;
				ST_RC:        state_reg <= ($countones(rc_reg) == 1) ? ST_FINISH : ST_RC;
				ST_FINISH:    state_reg <= ST_IDLE;
				ST_MUL_PICK:  state_reg <= ST_MUL_ADD;
				ST_MUL_ADD:   state_reg <= (cnt_reg == 4'h0) ? ST_MUL_SHIFT : ST_MUL_ADD;
				ST_MUL_SHIFT: state_reg <= (idx_reg != dec_alu_pkg::LAST_DIGIT) ? ST_MUL_PICK
				                           : (borrow_reg ? ST_MUL_FIX : ST_MUL_STORE);
				ST_MUL_FIX:   state_reg <= ST_MUL_STORE;
				ST_MUL_STORE: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Latches the instruction; memory operand lands in the operand register.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cpr_reg  <= dec_alu_pkg::AR_RESET;
			mask_reg <= 4'h0;
			dec_reg  <= 1'b0;
			sub_reg  <= 1'b0;
		end else if (state_reg == ST_IDLE && i_start) begin
			cpr_reg  <= i_mem_word;
			mask_reg <= i_ar_mask;
			dec_reg  <= i_decimal || (i_op == dec_alu_pkg::OP_MUL);
			sub_reg  <= i_op == dec_alu_pkg::OP_SUB;
		end
	end

	// Words waiting for recomplementation, one per cycle.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rc_reg <= 4'h0;
		end else if (state_reg == ST_ADD) begin
			rc_reg <= need_rc;
		end else if (state_reg == ST_RC) begin
			rc_reg[rc_idx] <= 1'b0;
		end
	end

	// *****************************************************************
	// Arithmetic registers
	// *****************************************************************
	// Loads, sums, recomplements, zero signs and product words.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int k = 0; k < dec_alu_pkg::NUM_AR; k++) begin
				ar_reg[k] <= dec_alu_pkg::AR_RESET;
			end
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (i_start && i_op == dec_alu_pkg::OP_MUL) begin
						ar_reg[dec_alu_pkg::PROD_HI] <= {1'b0, dec_alu_pkg::XS3_ZERO_MAG};
					end else if (i_load_en) begin
						ar_reg[i_load_sel] <= i_load_word;
					end
				end
				ST_ADD: begin
					for (int k = 0; k < dec_alu_pkg::NUM_AR; k++) begin
						if (mask_reg[k]) begin
							ar_reg[k][23:0] <= sum_w[k][23:0];
						end
					end
				end
				ST_RC: begin
					ar_reg[rc_idx] <= {~ar_reg[rc_idx][dec_alu_pkg::SIGN_POS],
					                   rc_val[23:0]};
				end
				ST_FINISH: begin
					for (int k = 0; k < dec_alu_pkg::NUM_AR; k++) begin
						if (mask_reg[k] && zero_w[k]) begin
							ar_reg[k][dec_alu_pkg::SIGN_POS] <= 1'b0;
						end
					end
				end
				ST_MUL_STORE: begin
					ar_reg[dec_alu_pkg::PROD_HI] <= {ar_reg[dec_alu_pkg::MUL_SRC][24] ^ cpr_reg[24],
					                                 acc_reg[23:0]};
					ar_reg[dec_alu_pkg::PROD_LO] <= {ar_reg[dec_alu_pkg::MUL_SRC][24] ^ cpr_reg[24],
					                                 lo_reg};
				end
				default: begin
				end
			endcase
		end
	end

	// *****************************************************************
	// Multiplier
	// *****************************************************************
	// Digit plus borrow picks multiple or its complement and a repeat count.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acc_reg     <= 28'h0;
			lo_reg      <= 24'h0;
			mq_reg      <= 24'h0;
			cnt_reg     <= 4'h0;
			idx_reg     <= 3'h0;
			borrow_reg  <= 1'b0;
			usecomp_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					acc_reg    <= ext(dec_alu_pkg::XS3_ZERO_MAG, 1'b1);
					lo_reg     <= dec_alu_pkg::XS3_ZERO_MAG;
					mq_reg     <= ar_reg[dec_alu_pkg::MUL_SRC][23:0];
					idx_reg    <= 3'h0;
					borrow_reg <= 1'b0;
				end
				ST_MUL_PICK: begin
					if (eff_digit > dec_alu_pkg::COMP_LIMIT) begin
						cnt_reg     <= dec_alu_pkg::RADIX - eff_digit;
						usecomp_reg <= 1'b1;
						borrow_reg  <= 1'b1;
					end else begin
						cnt_reg     <= eff_digit;
						usecomp_reg <= 1'b0;
						borrow_reg  <= 1'b0;
					end
				end
				ST_MUL_ADD: begin
					if (cnt_reg != 4'h0) begin
						acc_reg <= add_ext(acc_reg, usecomp_reg ? tc_ext(mcand_ext, 1'b1)
						                                        : mcand_ext, 1'b1);
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				ST_MUL_SHIFT: begin
					lo_reg  <= {acc_reg[3:0], lo_reg[23:4]};
					acc_reg <= {acc_reg[27:24], acc_reg[27:4]};
					mq_reg  <= {4'h0, mq_reg[23:4]};
					idx_reg <= idx_reg + 3'h1;
				end
				ST_MUL_FIX: acc_reg <= add_ext(acc_reg, mcand_ext, 1'b1);
				default: begin
				end
			endcase
		end
	end

	// *****************************************************************
	// Outputs
	// *****************************************************************
	// Busy, completion pulse and equal-comparison flag.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_eq_flag <= 1'b0;
		end else begin
			o_busy <= (state_reg == ST_IDLE) ? i_start
			          : !(state_reg == ST_FINISH || state_reg == ST_MUL_STORE);
			o_done <= state_reg == ST_FINISH || state_reg == ST_MUL_STORE;
			if (state_reg == ST_FINISH) begin
				o_eq_flag <= all_zero_w;
			end
		end
	end

	assign o_ar_words = {ar_reg[3], ar_reg[2], ar_reg[1], ar_reg[0]};

	// *****************************************************************
	// Checks
	// *****************************************************************
	chk_add_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_ADD && !(|need_rc) |=> state_reg == ST_FINISH ##1 o_done)
		else $error("add without recomplement took extra cycles");
	chk_rc_setup_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_ADD && (|need_rc) |=> state_reg == ST_RC_SETUP ##1 state_reg == ST_RC)
		else $error("recomplement did not cost its setup cycle");
	chk_rc_per_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_RC && $countones(rc_reg) == 2 |=> state_reg == ST_RC ##1
		state_reg == ST_FINISH)
		else $error("recomplement did not take one cycle per word");
	chk_equal_no_rc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_ADD && (ar_reg[0][24] == mem_sign) |-> !need_rc[0])
		else $error("equal signs asked for recomplement");
	chk_rc_sign_flip: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_RC |=> ar_reg[$past(rc_idx)][24] != $past(rc_sign_w))
		else $error("recomplement left the register sign");
	chk_zero_positive: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_FINISH && mask_reg[0] && zero_w[0] |=> !ar_reg[0][24] && o_done)
		else $error("zero result kept a negative sign");
	chk_eq_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_FINISH |=> o_eq_flag == $past(all_zero_w))
		else $error("equal flag does not follow zero result");
	chk_cpr_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_IDLE && i_start |=> cpr_reg == $past(i_mem_word) && o_busy)
		else $error("operand register missed the memory word");
	chk_mul_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_IDLE && i_start && i_op == dec_alu_pkg::OP_MUL |=>
		ar_reg[3][23:0] == dec_alu_pkg::XS3_ZERO_MAG && state_reg == ST_MUL_PICK)
		else $error("multiply did not clear the fourth register");
	chk_mul_sign: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_MUL_STORE |=> ar_reg[3][24] == (ar_reg[0][24] ^ cpr_reg[24]) && o_done)
		else $error("product sign wrong");
endmodule : signed_decimal_add_multiply

// File: sim/seq_mem_model.sv
// Control sequencer and memory stand-in that feeds the datapath.
`timescale 1ns/1ps
module seq_mem_model (
	// Clock.
	input  wire logic        i_clk,
	// Datapath status.
	input  wire logic        i_done,
	// Requests towards the datapath.
	output logic             o_load_en,
	output logic [1:0]       o_load_sel,
	output logic [24:0]      o_load_word,
	output logic             o_start,
	output logic [1:0]       o_op,
	output logic             o_decimal,
	output logic [3:0]       o_ar_mask,
	output logic [24:0]      o_mem_word
);
	// All requests sit idle from time zero.
	initial begin
		o_load_en   = 1'b0;
		o_load_sel  = 2'h0;
		o_load_word = 25'h0000000;
		o_start     = 1'b0;
		o_op        = 2'h0;
		o_decimal   = 1'b0;
		o_ar_mask   = 4'h0;
		o_mem_word  = 25'h0000000;
	end

	// Writes one whole word into one arithmetic register.
	task automatic load(input logic [1:0] sel, input logic [24:0] word);
		@(posedge i_clk);
		#1;
		o_load_en   = 1'b1;
		o_load_sel  = sel;
		o_load_word = word;
		@(posedge i_clk);
		#1;
		o_load_en   = 1'b0;
		o_load_word = ~word;
	endtask : load

	// Issues one instruction and counts edges until the done pulse.
	task automatic run(input logic [1:0] op, input logic dec, input logic [3:0] mask,
		input logic [24:0] mem, output int cycles);
		int n;
		n = 0;
		@(posedge i_clk);
		#1;
		o_start    = 1'b1;
		o_op       = op;
		o_decimal  = dec;
		o_ar_mask  = mask;
		o_mem_word = mem;
		@(posedge i_clk);
		#1;
		o_start    = 1'b0;
		// The memory bus is driven with the inverted word after capture, so stale data must not be used.
		o_mem_word = ~mem;
		n = 1;
		while (i_done !== 1'b1 && n < 300) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		cycles = n;
	endtask : run
endmodule : seq_mem_model

// File: sim/signed_decimal_add_multiply_tb_top.sv
// Self-checking bench for the signed decimal add and multiply datapath.
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; $display("[FAIL] %0t ns: got %h expected %h", $time, (got), (exp)); end end
module signed_decimal_add_multiply_tb_top;
	logic        i_clk = 1'b0;
	logic        i_rst_b;
	logic        load_en;
	logic [1:0]  load_sel;
	logic [24:0] load_word;
	logic        start;
	logic [1:0]  op;
	logic        decimal;
	logic [3:0]  ar_mask;
	logic [24:0] mem_word;
	logic        busy;
	logic        done;
	logic        eq_flag;
	logic [99:0] ar_words;
	int          mismatches = 0;
	int          n_compared = 0;
	int          cyc;

	// Sequencer model and the block under test.
	seq_mem_model i_seq (.i_clk(i_clk), .i_done(done), .o_load_en(load_en),
		.o_load_sel(load_sel), .o_load_word(load_word), .o_start(start), .o_op(op),
		.o_decimal(decimal), .o_ar_mask(ar_mask), .o_mem_word(mem_word));
	signed_decimal_add_multiply i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_load_en(load_en), .i_load_sel(load_sel), .i_load_word(load_word),
		.i_start(start), .i_op(op), .i_decimal(decimal), .i_ar_mask(ar_mask),
		.i_mem_word(mem_word), .o_busy(busy), .o_done(done), .o_eq_flag(eq_flag),
		.o_ar_words(ar_words));

	// A 100 ns clock.
	always #50 i_clk = ~i_clk;

	// Builds a signed excess-three word from a decimal magnitude.
	function automatic logic [24:0] dw(input logic neg, input int v);
		logic [24:0] w;
		w = {neg, 24'h000000};
		for (int i = 0; i < 6; i++) begin
			w[i*4 +: 4] = 4'((v / (10 ** i)) % 10) + 4'h3;
		end
		return w;
	endfunction : dw

	// Picks one arithmetic register out of the flat bus.
	function automatic logic [24:0] ar(input int k);
		return ar_words[k*25 +: 25];
	endfunction : ar

	// Like signs, both negative, with carries across digit groups.
	task automatic t_equal();
		i_seq.load(2'h0, dw(1, 226385));
		i_seq.load(2'h3, dw(1, 615));
		i_seq.load(2'h1, dw(0, 777));
		i_seq.run(dec_alu_pkg::OP_ADD, 1'b1, 4'h9, dw(1, 199999), cyc);
		`CHECK(cyc, 3)
		`CHECK(busy, 1'b0)
		`CHECK(ar(0), dw(1, 426384))
		`CHECK(ar(3), dw(1, 200614))
		`CHECK(ar(1), dw(0, 777))
		`CHECK(eq_flag, 1'b0)
	endtask : t_equal

	// Unlike signs without recomplement, mixed with a like-sign register.
	task automatic t_unequal();
		i_seq.load(2'h0, dw(0, 226385));
		i_seq.load(2'h1, dw(1, 226385));
		i_seq.run(dec_alu_pkg::OP_ADD, 1'b1, 4'h3, dw(1, 214360), cyc);
		`CHECK(cyc, 3)
		`CHECK(ar(0), dw(0, 12025))
		`CHECK(ar(1), dw(1, 440745))
		i_seq.load(2'h2, dw(1, 226385));
		i_seq.run(dec_alu_pkg::OP_ADD, 1'b1, 4'h4, dw(0, 214360), cyc);
		`CHECK(ar(2), dw(1, 12025))
		i_seq.load(2'h2, dw(0, 900000));
		i_seq.run(dec_alu_pkg::OP_ADD, 1'b1, 4'h4, dw(1, 100000), cyc);
		`CHECK(ar(2), dw(0, 800000))
	endtask : t_unequal

	// Recomplement of two words, then of one word.
	task automatic t_recomp();
		i_seq.load(2'h0, dw(0, 218684));
		i_seq.load(2'h1, dw(0, 500000));
		i_seq.load(2'h2, dw(0, 1));
		i_seq.run(dec_alu_pkg::OP_ADD, 1'b1, 4'h7, dw(1, 221896), cyc);
		`CHECK(cyc, 6)
		`CHECK(ar(0), dw(1, 3212))
		`CHECK(ar(1), dw(0, 278104))
		`CHECK(ar(2), dw(1, 221895))
		i_seq.load(2'h0, dw(1, 218684));
		i_seq.run(dec_alu_pkg::OP_ADD, 1'b1, 4'h1, dw(0, 221896), cyc);
		`CHECK(cyc, 5)
		`CHECK(ar(0), dw(0, 3212))
	endtask : t_recomp

	// Subtraction to a zero from a negative register, then a like-sign case.
	task automatic t_sub();
		i_seq.load(2'h0, dw(1, 5));
		i_seq.run(dec_alu_pkg::OP_SUB, 1'b1, 4'h1, dw(1, 5), cyc);
		`CHECK(ar(0), dw(0, 0))
		`CHECK(eq_flag, 1'b1)
		i_seq.load(2'h0, dw(1, 5));
		i_seq.run(dec_alu_pkg::OP_SUB, 1'b1, 4'h1, dw(0, 5), cyc);
		`CHECK(ar(0), dw(1, 10))
		`CHECK(eq_flag, 1'b0)
		i_seq.load(2'h2, 25'h000000f);
		i_seq.run(dec_alu_pkg::OP_ADD, 1'b0, 4'h4, 25'h0000001, cyc);
		`CHECK(ar(2), 25'h0000010)
		i_seq.run(dec_alu_pkg::OP_SUB, 1'b0, 4'h4, 25'h0000020, cyc);
		`CHECK(cyc, 5)
		`CHECK(ar(2), 25'h1000010)
	endtask : t_sub

	// Multiplications with unlike and with like signs.
	task automatic t_mul();
		i_seq.load(2'h0, dw(0, 123456));
		i_seq.load(2'h2, dw(0, 42));
		i_seq.load(2'h3, dw(0, 555555));
		i_seq.run(dec_alu_pkg::OP_MUL, 1'b1, 4'h0, dw(1, 789), cyc);
		`CHECK(ar(3), dw(1, 97))
		`CHECK(ar(1), dw(1, 406784))
		`CHECK(ar(2), dw(0, 42))
		i_seq.load(2'h0, dw(1, 999999));
		i_seq.run(dec_alu_pkg::OP_MUL, 1'b1, 4'h0, dw(1, 999999), cyc);
		`CHECK(ar(3), dw(0, 999998))
		`CHECK(ar(1), dw(0, 1))
	endtask : t_mul

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// Reset for 20 cycles, then every scenario in turn.
	initial begin
		i_rst_b = 1'b0;
		repeat (20) @(posedge i_clk);
		#1;
		i_rst_b = 1'b1;
		t_equal();
		t_unequal();
		t_recomp();
		t_sub();
		t_mul();
		test_done();
	end

	// Cuts a hang short at 3000 cycles, well past the expected run of under two hundred cycles.
	initial begin
		#(3000 * 100);
		mismatches++;
		test_done();
	end
endmodule : signed_decimal_add_multiply_tb_top
